// ### phy_system_bus_tx_sideband.sv
// PHY-side sideband control of the multi-port cell/packet system bus
`timescale 1ns/100ps
module phy_system_bus_tx_sideband
  import phy_sb_pkg::*;
(
  // Core clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  // Link clocks
  input  wire logic                          tx_system_clock,
  input  wire logic                          rx_system_clock,
  // Configuration from the core
  input  wire logic [1:0]                    cfg_bus_mode,
  input  wire logic [1:0]                    cfg_bus_width,
  input  wire logic                          cfg_dp_reset,
  // Per-port fill status from the core
  input  wire logic [phy_sb_pkg::NUM_PORTS-1:0] port_full,
  input  wire logic [phy_sb_pkg::NUM_PORTS-1:0] port_space_ok,
  // Transmit link pins
  input  wire logic                          tx_enable_n,
  input  wire logic [4:0]                    tx_port_addr,
  input  wire logic [31:0]                   tx_data,
  input  wire logic                          tx_start_of_transfer,
  input  wire logic                          tx_end_of_packet,
  input  wire logic [1:0]                    tx_byte_modulus,
  input  wire logic                          tx_packet_error,
  output logic                               tx_selected_space_avail,
  output logic                               tx_selected_space_avail_oe,
  // Word steering on the transmit clock
  output logic                               tx_word_valid,
  output logic [4:0]                         tx_word_port,
  output logic                               tx_word_last,
  output logic [1:0]                         tx_word_modulus,
  output logic                               tx_word_abort,
  // Packet completion on the core clock
  output logic                               pkt_done,
  output logic [4:0]                         pkt_done_port,
  output logic [1:0]                         pkt_done_modulus,
  output logic                               pkt_done_abort,
  // Receive link pins
  input  wire logic [4:0]                    rx_port_select,
  // Receive port selection on the core clock
  output logic                               rx_sel_update,
  output logic [4:0]                         rx_sel_port
);

  // ---------------- Core to transmit domain crossings ----------------
  logic [4:0]           tx_cfg_s;
  logic [1:0]           tx_mode;
  logic [1:0]           tx_width;
  logic                 tx_dpr;
  logic [NUM_PORTS-1:0] tx_full_s;
  logic [NUM_PORTS-1:0] tx_space_s;

  // Configuration is quasi-static, so a per-bit level crossing suffices
  sync_2ff #(.W(5)) u_tx_cfg_sync (
    .clk    (tx_system_clock),
    .arst_n (arst_n),
    .din    ({cfg_dp_reset, cfg_bus_width, cfg_bus_mode}),
    .dout   (tx_cfg_s)
  );

  assign tx_mode  = tx_cfg_s[1:0];
  assign tx_width = tx_cfg_s[3:2];
  assign tx_dpr   = tx_cfg_s[4];

  // Fill flags are levels; a two-cycle lag only delays the space flag
  sync_2ff #(.W(2 * NUM_PORTS)) u_tx_stat_sync (
    .clk    (tx_system_clock),
    .arst_n (arst_n),
    .din    ({port_space_ok, port_full}),
    .dout   ({tx_space_s, tx_full_s})
  );

  // Mode decode
  logic is_pkt;
  logic is_spi3;
  logic is_pkt_l2;
  logic is_cell;

  always_comb begin
    is_spi3   = (tx_mode == MODE_SPI3);
    is_pkt_l2 = (tx_mode == MODE_PKT_L2);
    is_pkt    = is_spi3 || is_pkt_l2;
    is_cell   = !is_pkt;
  end

  // ---------------- Transmit port selection ----------------
  sel_state_t sel_state_q;
  sel_state_t sel_state_d;
  logic [4:0] sel_port_q;
  logic [4:0] sel_port_d;
  logic [4:0] inband_addr;

  assign inband_addr = tx_data[INBAND_ADDR_MSB:INBAND_ADDR_LSB];

  // Out-of-range addresses deselect rather than alias onto a real port
  always_comb begin
    sel_state_d = sel_state_q;
    sel_port_d  = sel_port_q;
    if (tx_dpr || is_cell) begin
      sel_state_d = SEL_IDLE;
      sel_port_d  = PORT_NONE;
    end else begin
      case (sel_state_q)
        SEL_IDLE, SEL_HELD: begin
          if (is_spi3 && tx_enable_n && tx_start_of_transfer) begin
            sel_port_d  = inband_addr;
            sel_state_d = (inband_addr < PORT_LIMIT) ? SEL_HELD : SEL_IDLE;
          end else if (is_pkt_l2 && tx_enable_n) begin
            sel_port_d  = tx_port_addr;
            sel_state_d = (tx_port_addr < PORT_LIMIT) ? SEL_HELD : SEL_IDLE;
          end
        end
        default: begin
          sel_state_d = SEL_IDLE;
          sel_port_d  = PORT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge tx_system_clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_state_q <= SEL_IDLE;
      sel_port_q  <= PORT_NONE;
    end else begin
      sel_state_q <= sel_state_d;
      sel_port_q  <= sel_port_d;
    end
  end

  // ---------------- Word steering ----------------
  logic       word_valid_q;
  logic       word_valid_d;
  logic [4:0] word_port_q;
  logic [4:0] word_port_d;
  logic       word_last_q;
  logic       word_last_d;
  logic [1:0] word_mod_q;
  logic [1:0] word_mod_d;
  logic       word_abort_q;
  logic       word_abort_d;
  logic       word_xfer;

  // A word moves while enable is low and a port is held
  assign word_xfer = is_pkt && !tx_dpr && !tx_enable_n && (sel_state_q == SEL_HELD);

  always_comb begin
    word_valid_d = word_xfer;
    word_port_d  = word_xfer ? sel_port_q : word_port_q;
    word_last_d  = word_xfer && tx_end_of_packet;
    word_mod_d   = MOD_RST;
    word_abort_d = word_xfer && tx_end_of_packet && tx_packet_error;
    if (word_xfer && tx_end_of_packet && (tx_width == WIDTH_32)) begin
      word_mod_d = tx_byte_modulus;
    end
  end

  always_ff @(posedge tx_system_clock or negedge arst_n) begin
    if (!arst_n) begin
      word_valid_q <= 1'b0;
      word_port_q  <= PORT_NONE;
      word_last_q  <= 1'b0;
      word_mod_q   <= MOD_RST;
      word_abort_q <= 1'b0;
    end else begin
      word_valid_q <= word_valid_d;
      word_port_q  <= word_port_d;
      word_last_q  <= word_last_d;
      word_mod_q   <= word_mod_d;
      word_abort_q <= word_abort_d;
    end
  end

  assign tx_word_valid   = word_valid_q;
  assign tx_word_port    = word_port_q;
  assign tx_word_last    = word_last_q;
  assign tx_word_modulus = word_mod_q;
  assign tx_word_abort   = word_abort_q;

  // ---------------- Selected space flag and its enable ----------------
  logic                  spa_q;
  logic                  spa_d;
  logic                  spa_oe_q;
  logic                  spa_oe_d;
  logic [PORT_IDX_W-1:0] sel_idx;
  logic                  sel_full;
  logic                  sel_space;

  always_comb begin
    sel_idx   = sel_port_q[PORT_IDX_W-1:0];
    sel_full  = tx_full_s[sel_idx];
    sel_space = tx_space_s[sel_idx];
  end

  // Between full and the threshold the flag holds, giving hysteresis
  always_comb begin
    spa_d    = spa_q;
    spa_oe_d = OE_RST;
    case (tx_mode)
      MODE_UTOPIA_L2: begin
        spa_d    = 1'b0;
        spa_oe_d = 1'b0;
      end
      MODE_UTOPIA_L3: begin
        spa_d    = 1'b0;
        spa_oe_d = 1'b1;
      end
      MODE_PKT_L2, MODE_SPI3: begin
        if ((sel_state_q != SEL_HELD) || sel_full || tx_dpr) begin
          spa_d = 1'b0;
        end else if (sel_space) begin
          spa_d = 1'b1;
        end
        if (is_spi3) begin
          spa_oe_d = 1'b1;
        end else begin
          spa_oe_d = (sel_state_q == SEL_HELD) && !tx_enable_n && !tx_dpr;
        end
      end
      default: begin
        spa_d    = 1'b0;
        spa_oe_d = 1'b0;
      end
    endcase
  end

  // Registered on the transmit clock so the pin only moves on its edge
  always_ff @(posedge tx_system_clock or negedge arst_n) begin
    if (!arst_n) begin
      spa_q    <= SPACE_RST;
      spa_oe_q <= OE_RST;
    end else begin
      spa_q    <= spa_d;
      spa_oe_q <= spa_oe_d;
    end
  end

  assign tx_selected_space_avail    = spa_q;
  assign tx_selected_space_avail_oe = spa_oe_q;

  // ---------------- Packet completion, transmit side of crossing ----------------
  logic       done_tgl_q;
  logic       done_tgl_d;
  logic [4:0] done_port_q;
  logic [4:0] done_port_d;
  logic [1:0] done_mod_q;
  logic [1:0] done_mod_d;
  logic       done_abort_q;
  logic       done_abort_d;

  // Fields are held until the next end of packet, well past the toggle sync
  always_comb begin
    done_tgl_d   = done_tgl_q;
    done_port_d  = done_port_q;
    done_mod_d   = done_mod_q;
    done_abort_d = done_abort_q;
    if (word_last_q) begin
      done_tgl_d   = !done_tgl_q;
      done_port_d  = word_port_q;
      done_mod_d   = word_mod_q;
      done_abort_d = word_abort_q;
    end
  end

  always_ff @(posedge tx_system_clock or negedge arst_n) begin
    if (!arst_n) begin
      done_tgl_q   <= 1'b0;
      done_port_q  <= PORT_NONE;
      done_mod_q   <= MOD_RST;
      done_abort_q <= 1'b0;
    end else begin
      done_tgl_q   <= done_tgl_d;
      done_port_q  <= done_port_d;
      done_mod_q   <= done_mod_d;
      done_abort_q <= done_abort_d;
    end
  end

  // ---------------- Receive port address, receive side ----------------
  logic [1:0] rx_mode;
  logic       rx_addr_tgl_q;
  logic       rx_addr_tgl_d;
  logic [4:0] rx_addr_q;
  logic [4:0] rx_addr_d;
  logic [4:0] rx_held_q;
  logic [4:0] rx_held_d;

  sync_2ff #(.W(2)) u_rx_mode_sync (
    .clk    (rx_system_clock),
    .arst_n (arst_n),
    .din    (cfg_bus_mode),
    .dout   (rx_mode)
  );

  // Pins from the far side are already on this clock; no extra sync
  always_comb begin
    rx_addr_d     = rx_addr_q;
    rx_held_d     = rx_held_q;
    rx_addr_tgl_d = rx_addr_tgl_q;
    if (rx_mode != MODE_SPI3) begin
      rx_addr_d = rx_port_select;
    end
    if (rx_addr_q != rx_held_q) begin
      rx_held_d     = rx_addr_q;
      rx_addr_tgl_d = !rx_addr_tgl_q;
    end
  end

  always_ff @(posedge rx_system_clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_addr_q     <= PORT_NONE;
      rx_held_q     <= PORT_NONE;
      rx_addr_tgl_q <= 1'b0;
    end else begin
      rx_addr_q     <= rx_addr_d;
      rx_held_q     <= rx_held_d;
      rx_addr_tgl_q <= rx_addr_tgl_d;
    end
  end

  // ---------------- Core side of the event crossings ----------------
  logic [1:0] sys_tgl_s;
  logic [1:0] sys_tgl_seen_q;
  logic [1:0] sys_tgl_seen_d;

  sync_2ff #(.W(2)) u_sys_tgl_sync (
    .clk    (clk_sys),
    .arst_n (arst_n),
    .din    ({rx_addr_tgl_q, done_tgl_q}),
    .dout   (sys_tgl_s)
  );

  logic       pkt_done_q;
  logic       pkt_done_d;
  logic [4:0] pkt_port_q;
  logic [4:0] pkt_port_d;
  logic [1:0] pkt_mod_q;
  logic [1:0] pkt_mod_d;
  logic       pkt_abort_q;
  logic       pkt_abort_d;
  logic       rx_upd_q;
  logic       rx_upd_d;
  logic [4:0] rx_port_q;
  logic [4:0] rx_port_d;

  // Held fields are stable once the toggle edge arrives here
  always_comb begin
    sys_tgl_seen_d = sys_tgl_s;
    pkt_done_d     = (sys_tgl_s[0] != sys_tgl_seen_q[0]);
    pkt_port_d     = pkt_port_q;
    pkt_mod_d      = pkt_mod_q;
    pkt_abort_d    = pkt_abort_q;
    rx_upd_d       = (sys_tgl_s[1] != sys_tgl_seen_q[1]);
    rx_port_d      = rx_port_q;
    if (pkt_done_d) begin
      pkt_port_d  = done_port_q;
      pkt_mod_d   = done_mod_q;
      pkt_abort_d = done_abort_q;
    end
    if (rx_upd_d) begin
      rx_port_d = rx_held_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sys_tgl_seen_q <= 2'h0;
      pkt_done_q     <= 1'b0;
      pkt_port_q     <= PORT_NONE;
      pkt_mod_q      <= MOD_RST;
      pkt_abort_q    <= 1'b0;
      rx_upd_q       <= 1'b0;
      rx_port_q      <= PORT_NONE;
    end else begin
      sys_tgl_seen_q <= sys_tgl_seen_d;
      pkt_done_q     <= pkt_done_d;
      pkt_port_q     <= pkt_port_d;
      pkt_mod_q      <= pkt_mod_d;
      pkt_abort_q    <= pkt_abort_d;
      rx_upd_q       <= rx_upd_d;
      rx_port_q      <= rx_port_d;
    end
  end

  assign pkt_done         = pkt_done_q;
  assign pkt_done_port    = pkt_port_q;
  assign pkt_done_modulus = pkt_mod_q;
  assign pkt_done_abort   = pkt_abort_q;
  assign rx_sel_update    = rx_upd_q;
  assign rx_sel_port      = rx_port_q;

endmodule

// ### phy_sb_pkg.sv
// Shared constants for the system bus transmit sideband block
package phy_sb_pkg;

  // Bus protocol mode codes; the all-zero code is the reset mode (cell level 2)
  localparam logic [1:0] MODE_UTOPIA_L2 = 2'h0;
  localparam logic [1:0] MODE_UTOPIA_L3 = 2'h1;
  localparam logic [1:0] MODE_PKT_L2    = 2'h2;
  localparam logic [1:0] MODE_SPI3      = 2'h3;

  // Packet bus width codes; 8-bit is the reset width
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // Byte modulus codes on a 32-bit word, valid bytes counted from bit 31
  localparam logic [1:0] MOD_ALL4  = 2'h0;
  localparam logic [1:0] MOD_TOP3  = 2'h1;
  localparam logic [1:0] MOD_TOP2  = 2'h2;
  localparam logic [1:0] MOD_TOP1  = 2'h3;

  // Port addressing
  localparam int         NUM_PORTS   = 4;
  localparam int         PORT_IDX_W  = 2;
  localparam int         PORT_ADDR_W = 5;
  localparam logic [4:0] PORT_LIMIT  = 5'h04;
  localparam logic [4:0] PORT_NONE   = 5'h00;

  // Field positions of the in-band port address on the transmit data bus
  localparam int INBAND_ADDR_LSB = 0;
  localparam int INBAND_ADDR_MSB = 4;

  // Reset values
  localparam logic       SPACE_RST  = 1'b0;
  localparam logic       OE_RST     = 1'b0;
  localparam logic [1:0] MOD_RST    = 2'h0;

  // Far-side clock limits on the receive clock, in MHz
  localparam int RX_CLK_MAX_L3_MHZ = 66;
  localparam int RX_CLK_MAX_L2_MHZ = 52;

  // Selection state of the transmit side
  typedef enum logic {SEL_IDLE, SEL_HELD} sel_state_t;

endpackage

// ### sync_2ff.sv
// Two flip-flop level synchroniser, parameterised width
`timescale 1ns/100ps
module sync_2ff #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Level from the other domain and its synchronised copy
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

// ### phy_sb_checker.sv
// Port-level checker of the transmit sideband block
`timescale 1ns/100ps
module phy_sb_checker
  import phy_sb_pkg::*;
(
  // Clock and reset
  input wire logic                              tx_system_clock,
  input wire logic                              arst_n,
  // Configuration, status and enable
  input wire logic [1:0]                        cfg_bus_mode,
  input wire logic [1:0]                        cfg_bus_width,
  input wire logic [phy_sb_pkg::NUM_PORTS-1:0]  port_full,
  input wire logic                              tx_enable_n,
  // Watched outputs
  input wire logic                              tx_selected_space_avail,
  input wire logic                              tx_selected_space_avail_oe,
  input wire logic                              tx_word_valid,
  input wire logic                              tx_word_last,
  input wire logic [1:0]                        tx_word_modulus,
  input wire logic                              tx_word_abort
);
  default clocking cb @(posedge tx_system_clock); endclocking
  default disable iff (!arst_n);
  // Six steady edges cover two sync stages plus the output register
  property p_cell2_tri;
    (cfg_bus_mode == MODE_UTOPIA_L2)[*6] |-> !tx_selected_space_avail_oe;
  endproperty
  a_cell2_tri: assert property (p_cell2_tri) else $error("flag driven in cell L2");
  property p_cell3_low;
    (cfg_bus_mode == MODE_UTOPIA_L3)[*6] |-> tx_selected_space_avail_oe && !tx_selected_space_avail;
  endproperty
  a_cell3_low: assert property (p_cell3_low) else $error("flag not driven low in cell L3");
  property p_spi3_drv;
    (cfg_bus_mode == MODE_SPI3)[*6] |-> tx_selected_space_avail_oe;
  endproperty
  a_spi3_drv: assert property (p_spi3_drv) else $error("flag released in SPI-3");
  property p_pkt2_rel;
    (cfg_bus_mode == MODE_PKT_L2)[*6] ##0 tx_enable_n |=> !tx_selected_space_avail_oe;
  endproperty
  a_pkt2_rel: assert property (p_pkt2_rel) else $error("flag driven with enable off");
  property p_full_low;
    (port_full == 4'hf)[*6] |-> !tx_selected_space_avail;
  endproperty
  a_full_low: assert property (p_full_low) else $error("flag high while all full");
  property p_cell_no_eop;
    (!cfg_bus_mode[1])[*6] |-> !tx_word_last && !tx_word_abort;
  endproperty
  a_cell_no_eop: assert property (p_cell_no_eop) else $error("end marked in cell mode");
  property p_mod_eop;
    tx_word_valid && !tx_word_last |-> tx_word_modulus == MOD_ALL4;
  endproperty
  a_mod_eop: assert property (p_mod_eop) else $error("modulus on a middle word");
  property p_mod_width;
    (cfg_bus_width != WIDTH_32)[*6] ##0 tx_word_valid |-> tx_word_modulus == MOD_ALL4;
  endproperty
  a_mod_width: assert property (p_mod_width) else $error("modulus on narrow bus");
  property p_abort_eop;
    tx_word_abort |-> tx_word_valid && tx_word_last;
  endproperty
  a_abort_eop: assert property (p_abort_eop) else $error("abort without end word");
  c_last: cover property (tx_word_valid && tx_word_last && tx_word_modulus == MOD_TOP1);
  c_abort: cover property (tx_word_abort);
  c_space: cover property (tx_selected_space_avail_oe && tx_selected_space_avail);
endmodule

bind phy_system_bus_tx_sideband phy_sb_checker u_chk (
  .tx_system_clock(tx_system_clock), .arst_n(arst_n),
  .cfg_bus_mode(cfg_bus_mode), .cfg_bus_width(cfg_bus_width),
  .port_full(port_full), .tx_enable_n(tx_enable_n),
  .tx_selected_space_avail(tx_selected_space_avail),
  .tx_selected_space_avail_oe(tx_selected_space_avail_oe),
  .tx_word_valid(tx_word_valid), .tx_word_last(tx_word_last),
  .tx_word_modulus(tx_word_modulus), .tx_word_abort(tx_word_abort)
);

// ### phy_sb_link_model.sv
// Link-layer controller model driving the transmit and receive link pins
`timescale 1ns/100ps
module phy_sb_link_model (
  // Link clocks
  input  wire logic        tx_system_clock,
  input  wire logic        rx_system_clock,
  // Transmit link pins
  output logic             tx_enable_n,
  output logic [4:0]       tx_port_addr,
  output logic [31:0]      tx_data,
  output logic             tx_start_of_transfer,
  output logic             tx_end_of_packet,
  output logic [1:0]       tx_byte_modulus,
  output logic             tx_packet_error,
  // Receive address pins
  output logic [4:0]       rx_port_select
);
  // Quiet pins at time zero
  initial begin
    tx_enable_n = 1'b1;
    tx_port_addr = 5'h00;
    tx_data = 32'h0;
    tx_start_of_transfer = 1'b0;
    tx_end_of_packet = 1'b0;
    tx_byte_modulus = 2'h0;
    tx_packet_error = 1'b0;
    rx_port_select = 5'h00;
  end
  // Address cycle; upper data bits are noise so only the low five can matter
  task automatic addr_cycle(input logic [4:0] inband, input logic [4:0] oob);
    @(posedge tx_system_clock);
    tx_enable_n <= 1'b1;
    tx_start_of_transfer <= 1'b1;
    tx_data <= {27'($urandom()), inband};
    tx_port_addr <= oob;
    tx_end_of_packet <= 1'b0;
    tx_packet_error <= 1'b0;
  endtask
  // One word; modulus is noise except on the last word
  task automatic word(input logic last, input logic [1:0] m, input logic e,
                      input logic sx, input logic [4:0] a);
    @(posedge tx_system_clock);
    tx_enable_n <= 1'b0;
    tx_start_of_transfer <= sx;
    tx_data <= {27'($urandom()), a};
    tx_end_of_packet <= last;
    tx_byte_modulus <= last ? m : 2'($urandom());
    tx_packet_error <= last & e;
  endtask
  // Enable off between bursts, data keeps changing
  task automatic idle();
    @(posedge tx_system_clock);
    tx_enable_n <= 1'b1;
    tx_start_of_transfer <= 1'b0;
    tx_end_of_packet <= 1'b0;
    tx_packet_error <= 1'b0;
    tx_data <= $urandom();
  endtask
  // Receive address held four receive clocks so every change is seen
  task automatic rx_go(input logic [4:0] a);
    @(posedge rx_system_clock);
    rx_port_select <= a;
    repeat (3) @(posedge rx_system_clock);
  endtask
endmodule

// ### phy_system_bus_tx_sideband_tb.sv
// Self-checking bench of the transmit sideband block
`timescale 1ns/100ps
module phy_system_bus_tx_sideband_tb;
  import phy_sb_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, tx_system_clock = 1'b0, rx_system_clock = 1'b0;
  logic [1:0] cfg_bus_mode = MODE_UTOPIA_L2, cfg_bus_width = WIDTH_8;
  logic cfg_dp_reset = 1'b0;
  logic [3:0] port_full = 4'h0, port_space_ok = 4'hf;
  logic tx_enable_n, tx_start_of_transfer, tx_end_of_packet, tx_packet_error;
  logic [4:0] tx_port_addr, rx_port_select, tx_word_port, rx_sel_port, p, a;
  logic [31:0] tx_data;
  logic [1:0] tx_byte_modulus, tx_word_modulus;
  logic tx_selected_space_avail, tx_selected_space_avail_oe, tx_word_valid;
  logic tx_word_last, tx_word_abort, rx_sel_update;
  logic pkt_done, pkt_done_abort;
  logic [1:0] pkt_done_modulus;
  logic [4:0] pkt_done_port;
  logic [8:0] txq[$];
  logic [4:0] rxq[$];
  logic [7:0] pdq[$];
  logic [8:0] exp_w;
  int errors = 0, compares = 0;
  wire [8:0] word_seen = {tx_word_port, tx_word_last, tx_word_modulus, tx_word_abort};
  wire [7:0] done_seen = {pkt_done_port, pkt_done_modulus, pkt_done_abort};
  // Clocks; the receive clock runs far below its limit, offset in phase
  always #2 clk_sys = ~clk_sys;
  always #62.5 tx_system_clock = ~tx_system_clock;
  initial #17.3 forever #62.5 rx_system_clock = ~rx_system_clock;
  phy_system_bus_tx_sideband u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .tx_system_clock(tx_system_clock),
    .rx_system_clock(rx_system_clock), .cfg_bus_mode(cfg_bus_mode),
    .cfg_bus_width(cfg_bus_width), .cfg_dp_reset(cfg_dp_reset), .port_full(port_full),
    .port_space_ok(port_space_ok), .tx_enable_n(tx_enable_n), .tx_port_addr(tx_port_addr),
    .tx_data(tx_data), .tx_start_of_transfer(tx_start_of_transfer),
    .tx_end_of_packet(tx_end_of_packet), .tx_byte_modulus(tx_byte_modulus),
    .tx_packet_error(tx_packet_error), .tx_selected_space_avail(tx_selected_space_avail),
    .tx_selected_space_avail_oe(tx_selected_space_avail_oe), .tx_word_valid(tx_word_valid),
    .tx_word_port(tx_word_port), .tx_word_last(tx_word_last),
    .tx_word_modulus(tx_word_modulus), .tx_word_abort(tx_word_abort), .pkt_done(pkt_done),
    .pkt_done_port(pkt_done_port), .pkt_done_modulus(pkt_done_modulus),
    .pkt_done_abort(pkt_done_abort),
    .rx_port_select(rx_port_select), .rx_sel_update(rx_sel_update), .rx_sel_port(rx_sel_port)
  );
  phy_sb_link_model u_link (
    .tx_system_clock(tx_system_clock), .rx_system_clock(rx_system_clock),
    .tx_enable_n(tx_enable_n), .tx_port_addr(tx_port_addr), .tx_data(tx_data),
    .tx_start_of_transfer(tx_start_of_transfer), .tx_end_of_packet(tx_end_of_packet),
    .tx_byte_modulus(tx_byte_modulus), .tx_packet_error(tx_packet_error),
    .rx_port_select(rx_port_select)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic test_done();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Config is quasi-static, so let it settle through the syncs
  task automatic set_cfg(input logic [1:0] m, input logic [1:0] w);
    @(posedge clk_sys);
    cfg_bus_mode <= m;
    cfg_bus_width <= w;
    repeat (8) @(posedge tx_system_clock);
    // End off the edge so a following look sees settled outputs
    @(negedge tx_system_clock);
  endtask
  // Word monitor; a word nobody expected is a mismatch too
  always @(negedge tx_system_clock) begin
    if (tx_word_valid === 1'b1) begin
      if (txq.size() == 0) check(32'h1, 32'h0);
      else begin
        exp_w = txq.pop_front();
        check(32'(word_seen), 32'(exp_w));
        // Every expected end word must surface once more on the core side
        if (exp_w[3]) pdq.push_back({exp_w[8:4], exp_w[2:0]});
      end
    end
  end
  // Packet completion monitor on the core clock
  always @(negedge clk_sys) begin
    if (pkt_done === 1'b1) begin
      if (pdq.size() == 0) check(32'h1, 32'h0);
      else check(32'(done_seen), 32'(pdq.pop_front()));
    end
  end
  // Receive selection monitor
  always @(negedge clk_sys) begin
    if (rx_sel_update === 1'b1) begin
      if (rxq.size() == 0) check(32'h1, 32'h0);
      else check(32'(rx_sel_port), 32'(rxq.pop_front()));
    end
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'hc3c0));
    repeat (3) @(posedge tx_system_clock);
    arst_n <= 1'b1;
    repeat (4) @(negedge tx_system_clock);
    check(32'(tx_selected_space_avail_oe), 32'h0);
    set_cfg(MODE_SPI3, WIDTH_32);
    check(32'({tx_selected_space_avail_oe, tx_selected_space_avail}), 32'h2);
    p = 5'($urandom_range(3));
    u_link.addr_cycle(p, 5'($urandom()));
    for (int k = 0; k < 4; k++) begin
      txq.push_back({p, 1'b1, 2'(k), 1'b0});
      u_link.word(1'b1, 2'(k), 1'b0, 1'b0, 5'h00);
    end
    // Start flag with enable low must not move the selection
    txq.push_back({p, 4'h0});
    u_link.word(1'b0, 2'h0, 1'b0, 1'b1, p ^ 5'h1);
    txq.push_back({p, 1'b1, MOD_TOP2, 1'b1});
    u_link.word(1'b1, MOD_TOP2, 1'b1, 1'b0, 5'h00);
    u_link.idle();
    repeat (3) @(negedge tx_system_clock);
    check(32'({tx_selected_space_avail_oe, tx_selected_space_avail}), 32'h3);
    @(posedge clk_sys) port_full <= 4'hf;
    repeat (6) @(negedge tx_system_clock);
    check(32'(tx_selected_space_avail), 32'h0);
    @(posedge clk_sys) port_full <= 4'h0;
    set_cfg(MODE_SPI3, WIDTH_16);
    u_link.addr_cycle(p, 5'h1f);
    txq.push_back({p, 1'b1, 2'h0, 1'b0});
    u_link.word(1'b1, MOD_TOP1, 1'b0, 1'b0, 5'h00);
    u_link.idle();
    set_cfg(MODE_PKT_L2, WIDTH_32);
    a = 5'($urandom_range(3));
    u_link.addr_cycle(a ^ 5'h1, a);
    txq.push_back({a, 1'b1, MOD_TOP3, 1'b0});
    u_link.word(1'b1, MOD_TOP3, 1'b0, 1'b0, 5'h00);
    u_link.idle();
    repeat (3) @(negedge tx_system_clock);
    check(32'(tx_selected_space_avail_oe), 32'h0);
    // Data path reset must deselect: no word taken, pin released
    @(posedge clk_sys) cfg_dp_reset <= 1'b1;
    repeat (3) @(posedge tx_system_clock);
    u_link.word(1'b0, 2'h0, 1'b0, 1'b0, 5'h00);
    u_link.idle();
    @(negedge tx_system_clock);
    check(32'({tx_selected_space_avail_oe, tx_selected_space_avail}), 32'h0);
    @(posedge clk_sys) cfg_dp_reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      a = rx_port_select + 5'(1 + $urandom_range(2));
      rxq.push_back(a);
      u_link.rx_go(a);
    end
    set_cfg(MODE_UTOPIA_L3, WIDTH_32);
    check(32'({tx_selected_space_avail_oe, tx_selected_space_avail}), 32'h2);
    set_cfg(MODE_SPI3, WIDTH_32);
    u_link.rx_go(rx_port_select + 5'h3);
    repeat (8) @(negedge tx_system_clock);
    check(32'(txq.size() + rxq.size() + pdq.size()), 32'h0);
    test_done();
  end
endmodule
